// ===== rtl/dqlc_top.sv
// Reference qualification and loop control with AXI4-Lite register access
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
`include "dqlc_map.svh"
module dqlc_top #(
  parameter int TICK_CYCLES = `DQLC_TICK_US * 1000 / `DQLC_CLK_NS,
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Monitor pins and core status
  input wire dqlc_pkg::dqlc_mon_t mon_fail,
  input wire dqlc_pkg::dqlc_rate_t ref_rate,
  input wire logic ref_switch,
  // Results to the DPLL core
  output dqlc_pkg::dqlc_cfg_t loop_cfg,
  output logic phase_buildout,
  output logic phase_realign,
  output logic holdover_update,
  output logic [2:0] switch_fail,
  output logic [2:0] holdover_fail
);
  import dqlc_pkg::*;

  if (ADDR_W < 8 || TICK_CYCLES < 2) begin : g_chk
    $error("dqlc_top: ADDR_W below 8 or TICK_CYCLES below 2");
  end

  // ************************************************************
  // Registers and bus slave
  // ************************************************************
  logic [7:0] range_q;
  logic [7:0] smask_q;
  dqlc_delays_t delay_q;
  dqlc_loopa_t loopa_q;
  dqlc_loopb_t loopb_q;
  logic [7:0] fmask_q;
  logic [2:0] soak_fail;
  logic aw_hold_q;
  logic w_hold_q;
  logic [5:0] widx_q;
  logic [7:0] wdata_q;
  logic wstrb_q;
  logic wr_fire;
  logic wr_hit;
  logic [5:0] ridx;
  logic rd_hit;
  logic [7:0] rd_byte;

  assign wr_fire = aw_hold_q && w_hold_q && !bvalid;
  assign wr_hit = widx_q inside {`DQLC_IDX_RANGE, `DQLC_IDX_SMASK, `DQLC_IDX_DELAY,
                                 `DQLC_IDX_LOOPA, `DQLC_IDX_LOOPB, `DQLC_IDX_FMASK};

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      awready <= 1'b0;
      widx_q <= 6'h00;
    end else if (awvalid && awready) begin
      aw_hold_q <= 1'b1;
      awready <= 1'b0;
      widx_q <= awaddr[7:2];
    end else if (wr_fire) begin
      aw_hold_q <= 1'b0;
    end else if (!aw_hold_q && !bvalid) begin
      awready <= 1'b1;
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      wready <= 1'b0;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
    end else if (wvalid && wready) begin
      w_hold_q <= 1'b1;
      wready <= 1'b0;
      wdata_q <= wdata[7:0];
      wstrb_q <= wstrb[0];
    end else if (wr_fire) begin
      w_hold_q <= 1'b0;
    end else if (!w_hold_q && !bvalid) begin
      wready <= 1'b1;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `DQLC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= wr_hit ? `DQLC_RESP_OKAY : `DQLC_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Register store; reserved bits are kept as written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      range_q <= `DQLC_RST_RANGE;
      smask_q <= `DQLC_RST_SMASK;
      delay_q <= `DQLC_RST_DELAY;
      loopa_q <= `DQLC_RST_LOOPA;
      loopb_q <= `DQLC_RST_LOOPB;
      fmask_q <= `DQLC_RST_FMASK;
    end else if (wr_fire && wstrb_q) begin
      case (widx_q)
        `DQLC_IDX_RANGE: range_q <= wdata_q;
        `DQLC_IDX_SMASK: smask_q <= wdata_q;
        `DQLC_IDX_DELAY: delay_q <= wdata_q;
        `DQLC_IDX_LOOPA: loopa_q <= wdata_q;
        `DQLC_IDX_LOOPB: loopb_q <= wdata_q;
        `DQLC_IDX_FMASK: fmask_q <= wdata_q;
        default: ;
      endcase
    end
  end

  // Read decode
  assign ridx = araddr[7:2];
  always_comb begin
    rd_hit = 1'b1;
    case (ridx)
      `DQLC_IDX_RANGE: rd_byte = range_q;
      `DQLC_IDX_SMASK: rd_byte = smask_q;
      `DQLC_IDX_DELAY: rd_byte = delay_q;
      `DQLC_IDX_LOOPA: rd_byte = loopa_q;
      `DQLC_IDX_LOOPB: rd_byte = loopb_q;
      `DQLC_IDX_FMASK: rd_byte = fmask_q;
      `DQLC_IDX_STAT: rd_byte = {5'h00, soak_fail};
      default: begin
        rd_hit = 1'b0;
        rd_byte = 8'h00;
      end
    endcase
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `DQLC_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, rd_byte};
      rresp <= rd_hit ? `DQLC_RESP_OKAY : `DQLC_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // ************************************************************
  // Monitor inputs and soak timers
  // ************************************************************
  dqlc_mon_t mon_s1_q;
  dqlc_mon_t mon_q;
  logic tick;
  logic [16:0] drop_ticks;
  logic [21:0] requal_ticks;
  logic [2:0] soak_in;

  // Two-flop synchroniser for the monitor pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mon_s1_q <= '0;
      mon_q <= '0;
    end else begin
      mon_s1_q <= mon_fail;
      mon_q <= mon_s1_q;
    end
  end

  dqlc_tick_div #(.DIV(TICK_CYCLES)) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick)
  );

  // Disqualify delay in ticks from its code
  function automatic logic [16:0] drop_of(input logic [3:0] code);
    int us;
    case (code)
      4'h1: us = `DQLC_DQ_1_US;
      4'h2: us = `DQLC_DQ_2_US;
      4'h3: us = `DQLC_DQ_3_US;
      4'h4: us = `DQLC_DQ_4_US;
      4'h5: us = `DQLC_DQ_5_US;
      4'h6: us = `DQLC_DQ_6_US;
      4'h7: us = `DQLC_DQ_7_US;
      4'h8: us = `DQLC_DQ_8_US;
      4'h9: us = `DQLC_DQ_9_US;
      4'ha: us = `DQLC_DQ_10_US;
      4'hb: us = `DQLC_DQ_11_US;
      4'hc: us = `DQLC_DQ_12_US;
      4'hd: us = `DQLC_DQ_13_US;
      4'he: us = `DQLC_DQ_14_US;
      4'hf: us = `DQLC_DQ_15_US;
      default: us = 0;
    endcase
    return 17'(us / `DQLC_TICK_US);
  endfunction

  assign drop_ticks = drop_of(delay_q.drop);
  // Requalify multiplier 2, 4, 16 or 32 as a shift
  always_comb begin
    case (delay_q.requal)
      2'h0: requal_ticks = {5'h00, drop_ticks} << 1;
      2'h1: requal_ticks = {5'h00, drop_ticks} << 2;
      2'h2: requal_ticks = {5'h00, drop_ticks} << 4;
      default: requal_ticks = {5'h00, drop_ticks} << 5;
    endcase
  end

  // Per-reference soak and failure indicator masking
  for (genvar i = 0; i < 3; i++) begin : g_ref
    logic [3:0] ind;
    assign soak_in[i] = (mon_q.single_cycle_monitor[i] && !smask_q[2*i]) ||
                        (mon_q.coarse_frequency_monitor[i] && !smask_q[2*i+1]);
    dqlc_soak_timer u_soak (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick),
      .fail_in(soak_in[i]),
      .drop_ticks(drop_ticks),
      .requal_ticks(requal_ticks),
      .failed(soak_fail[i])
    );
    // Indicator order: single-cycle, coarse, soak, precise
    assign ind = {mon_q.precise_frequency_monitor[i], soak_fail[i], mon_q.coarse_frequency_monitor[i], mon_q.single_cycle_monitor[i]};
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        switch_fail[i] <= 1'b0;
        holdover_fail[i] <= 1'b0;
      end else begin
        switch_fail[i] <= |(ind & fmask_q[3:0]);
        holdover_fail[i] <= |(ind & fmask_q[7:4]);
      end
    end
  end

  // ************************************************************
  // Loop configuration and switch handling
  // ************************************************************
  dqlc_bw_t bw_d;
  logic [16:0] hu_ticks;
  logic [16:0] hu_cnt_q;

  // Effective bandwidth with low-rate clamp; reserved code keeps the last value
  always_comb begin
    case (loopa_q.bw)
      3'h0: bw_d = BW_0P1;
      3'h1: bw_d = BW_1P7;
      3'h2: bw_d = BW_3P5;
      3'h3: bw_d = BW_14;
      3'h4: bw_d = (ref_rate == RATE_2K) ? BW_14 : BW_28;
      3'h5: bw_d = (ref_rate == RATE_2K) ? BW_14 : (ref_rate == RATE_8K) ? BW_56 : BW_890;
      3'h6: bw_d = BW_FAST7;
      default: bw_d = loop_cfg.bw;
    endcase
  end

  // Configuration register toward the core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loop_cfg <= '{range_limit: 3'h3, bw: BW_FAST7, slope: SLOPE_NONE, revertive: 1'b0,
                    offset_en: 1'b0, smooth: 2'h0};
    end else begin
      loop_cfg.range_limit <= range_q[2:0];
      loop_cfg.bw <= bw_d;
      loop_cfg.slope <= loopa_q.slope;
      loop_cfg.revertive <= loopb_q.revert;
      loop_cfg.offset_en <= loopb_q.offset_en;
      loop_cfg.smooth <= loopb_q.smooth;
    end
  end

  // Reference switch: build out or realign
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_buildout <= 1'b0;
      phase_realign <= 1'b0;
    end else begin
      phase_buildout <= ref_switch && !loopa_q.realign;
      phase_realign <= ref_switch && loopa_q.realign;
    end
  end

  // Holdover refresh interval in ticks
  always_comb begin
    case (loopb_q.upd)
      2'h0: hu_ticks = 17'(`DQLC_HU_0_US / `DQLC_TICK_US);
      2'h1: hu_ticks = 17'(`DQLC_HU_1_US / `DQLC_TICK_US);
      2'h2: hu_ticks = 17'(`DQLC_HU_2_US / `DQLC_TICK_US);
      default: hu_ticks = 17'(`DQLC_HU_3_US / `DQLC_TICK_US);
    endcase
  end

  // Holdover refresh pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hu_cnt_q <= 17'h0_0000;
      holdover_update <= 1'b0;
    end else if (tick && hu_cnt_q >= hu_ticks - 17'h0_0001) begin
      hu_cnt_q <= 17'h0_0000;
      holdover_update <= 1'b1;
    end else begin
      hu_cnt_q <= tick ? hu_cnt_q + 17'h0_0001 : hu_cnt_q;
      holdover_update <= 1'b0;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_range_sel;
    1'b1 |=> loop_cfg.range_limit == $past(range_q[2:0]);
  endproperty
  a_range_sel: assert property (p_range_sel) else $error("range limit not applied");

  property p_soak_mask;
    (smask_q[1:0] == 2'h3) |-> !soak_in[0];
  endproperty
  a_soak_mask: assert property (p_soak_mask) else $error("masked monitor reached soak");

  property p_buildout;
    (ref_switch && !loopa_q.realign) |=> phase_buildout && !phase_realign;
  endproperty
  a_buildout: assert property (p_buildout) else $error("switch not built out");

  property p_realign;
    (ref_switch && loopa_q.realign) |=> phase_realign && !phase_buildout;
  endproperty
  a_realign: assert property (p_realign) else $error("switch not realigned");

  property p_fast_lock;
    (loopa_q.bw == 3'h6) |=> loop_cfg.bw == BW_FAST7;
  endproperty
  a_fast_lock: assert property (p_fast_lock) else $error("fast lock not selected");

  property p_clamp_2k;
    (loopa_q.bw inside {3'h4, 3'h5} && ref_rate == RATE_2K) |=> loop_cfg.bw == BW_14;
  endproperty
  a_clamp_2k: assert property (p_clamp_2k) else $error("2 kHz clamp missing");

  property p_clamp_8k;
    (loopa_q.bw == 3'h5 && ref_rate == RATE_8K) |=> loop_cfg.bw == BW_56;
  endproperty
  a_clamp_8k: assert property (p_clamp_8k) else $error("8 kHz clamp missing");

  property p_offset_en;
    $rose(loopb_q.offset_en) |=> loop_cfg.offset_en;
  endproperty
  a_offset_en: assert property (p_offset_en) else $error("offset enable not applied");

  property p_fail_masked;
    (fmask_q[3:0] == 4'h0)[*2] |-> switch_fail == 3'h0;
  endproperty
  a_fail_masked: assert property (p_fail_masked) else $error("masked failure raised switching");

  property p_wr_answer;
    wr_fire |=> bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write not answered");

  c_write: cover property (wr_fire && wr_hit);
  c_read: cover property (rvalid && rready);
  c_switch: cover property (phase_realign);
endmodule

// ===== pkg/dqlc_map.svh
// Register indices, reset values and timing counts for the reference qualification block
`ifndef DQLC_MAP_SVH
`define DQLC_MAP_SVH

// Register indices (byte address is four times the index)
`define DQLC_IDX_RANGE 6'h17
`define DQLC_IDX_SMASK 6'h1a
`define DQLC_IDX_DELAY 6'h1c
`define DQLC_IDX_LOOPA 6'h1d
`define DQLC_IDX_LOOPB 6'h1e
`define DQLC_IDX_FMASK 6'h21
`define DQLC_IDX_STAT 6'h22

// Reset values
`define DQLC_RST_RANGE 8'h33
`define DQLC_RST_SMASK 8'hff
`define DQLC_RST_DELAY 8'h1a
`define DQLC_RST_LOOPA 8'h3c
`define DQLC_RST_LOOPB 8'h04
`define DQLC_RST_FMASK 8'h3c

// Bus answers
`define DQLC_RESP_OKAY 2'h0
`define DQLC_RESP_SLVERR 2'h2

// Clock period and soak time base
`define DQLC_CLK_NS 100
`define DQLC_TICK_US 500

// Disqualify delays in microseconds
`define DQLC_DQ_1_US 500
`define DQLC_DQ_2_US 1000
`define DQLC_DQ_3_US 5000
`define DQLC_DQ_4_US 10000
`define DQLC_DQ_5_US 50000
`define DQLC_DQ_6_US 100000
`define DQLC_DQ_7_US 500000
`define DQLC_DQ_8_US 1000000
`define DQLC_DQ_9_US 2000000
`define DQLC_DQ_10_US 2500000
`define DQLC_DQ_11_US 4000000
`define DQLC_DQ_12_US 8000000
`define DQLC_DQ_13_US 16000000
`define DQLC_DQ_14_US 32000000
`define DQLC_DQ_15_US 64000000

// Holdover update intervals in microseconds
`define DQLC_HU_0_US 26000
`define DQLC_HU_1_US 1000000
`define DQLC_HU_2_US 10000000
`define DQLC_HU_3_US 60000000

`endif

// ===== pkg/dqlc_pkg.sv
// Types shared by the reference qualification and loop control block
package dqlc_pkg;

  // Detected rate class of the active reference
  typedef enum logic [1:0] {
    RATE_OTHER = 2'h0,
    RATE_2K = 2'h1,
    RATE_8K = 2'h2,
    RATE_RSVD = 2'h3
  } dqlc_rate_t;

  // Effective loop bandwidth handed to the loop filter
  typedef enum logic [3:0] {
    BW_0P1 = 4'h0,
    BW_1P7 = 4'h1,
    BW_3P5 = 4'h2,
    BW_14 = 4'h3,
    BW_28 = 4'h4,
    BW_890 = 4'h5,
    BW_FAST7 = 4'h6,
    BW_56 = 4'h8
  } dqlc_bw_t;

  // Output phase slope limit
  typedef enum logic [1:0] {
    SLOPE_885N = 2'h0,
    SLOPE_7U5 = 2'h1,
    SLOPE_61U = 2'h2,
    SLOPE_NONE = 2'h3
  } dqlc_slope_t;

  // Soak timer state
  typedef enum logic {
    SOAK_OK = 1'b0,
    SOAK_FAIL = 1'b1
  } dqlc_soak_st_t;

  // Register layouts
  typedef struct packed {
    logic [1:0] rsvd;
    dqlc_slope_t slope;
    logic [2:0] bw;
    logic realign;
  } dqlc_loopa_t;

  typedef struct packed {
    logic [1:0] smooth;
    logic [1:0] upd;
    logic [1:0] rsvd;
    logic offset_en;
    logic revert;
  } dqlc_loopb_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic [1:0] requal;
    logic [3:0] drop;
  } dqlc_delays_t;

  // Monitor failure inputs, one bit per reference
  typedef struct packed {
    logic [2:0] single_cycle_monitor;
    logic [2:0] coarse_frequency_monitor;
    logic [2:0] precise_frequency_monitor;
  } dqlc_mon_t;

  // Loop configuration handed to the DPLL core
  typedef struct packed {
    logic [2:0] range_limit;
    dqlc_bw_t bw;
    dqlc_slope_t slope;
    logic revertive;
    logic offset_en;
    logic [1:0] smooth;
  } dqlc_cfg_t;

endpackage

// ===== rtl/dqlc_tick_div.sv
// Divider that makes the one-cycle soak time base enable
`timescale 1ns/10ps
module dqlc_tick_div #(
  parameter int DIV = 5000
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Enable pulse out
  output logic tick
);
  logic [31:0] cnt_q;

  if (DIV < 2) begin : g_chk
    $error("dqlc_tick_div: DIV must be at least 2");
  end

  // Count up one period, pulse on wrap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (cnt_q == 32'(DIV - 1)) begin
      cnt_q <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
      tick <= 1'b0;
    end
  end
endmodule

// ===== rtl/dqlc_soak_timer.sv
// Guard soak timer for one reference
`timescale 1ns/10ps
module dqlc_soak_timer (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Time base and unmasked failure
  input wire logic tick,
  input wire logic fail_in,
  // Delays in ticks
  input wire logic [16:0] drop_ticks,
  input wire logic [21:0] requal_ticks,
  // Soak result
  output logic failed
);
  import dqlc_pkg::*;

  dqlc_soak_st_t st_q;
  logic [21:0] cnt_q;

  // Failure must persist for the drop delay, cleanliness for the requalify delay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= SOAK_OK;
      cnt_q <= 22'h00_0000;
    end else begin
      case (st_q)
        SOAK_OK: begin
          if (!fail_in) begin
            cnt_q <= 22'h00_0000;
          end else if (cnt_q >= {5'h00, drop_ticks}) begin
            st_q <= SOAK_FAIL;
            cnt_q <= 22'h00_0000;
          end else if (tick) begin
            cnt_q <= cnt_q + 22'h00_0001;
          end
        end
        SOAK_FAIL: begin
          if (fail_in) begin
            cnt_q <= 22'h00_0000;
          end else if (cnt_q >= requal_ticks) begin
            st_q <= SOAK_OK;
            cnt_q <= 22'h00_0000;
          end else if (tick) begin
            cnt_q <= cnt_q + 22'h00_0001;
          end
        end
        default: begin
          st_q <= SOAK_OK;
          cnt_q <= 22'h00_0000;
        end
      endcase
    end
  end

  assign failed = (st_q == SOAK_FAIL);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Assertions on the soak decision
  property p_fail_needs_cause;
    $rose(failed) |-> $past(fail_in);
  endproperty
  a_fail_needs_cause: assert property (p_fail_needs_cause) else $error("soak failed without failure");

  property p_clear_needs_clean;
    $fell(failed) |-> !$past(fail_in);
  endproperty
  a_clear_needs_clean: assert property (p_clear_needs_clean) else $error("soak cleared while failing");

  property p_zero_delay;
    (st_q == SOAK_OK && fail_in && drop_ticks == 17'h0_0000) |=> failed;
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero drop delay not immediate");

  c_soak_fail: cover property ($rose(failed));
  c_soak_clear: cover property ($fell(failed));
endmodule

// ===== test/dqlc_ref_model.sv
// Reference source model: monitor pins, rate class and switch pulse
`timescale 1ns/10ps
module dqlc_ref_model (
  // Clock
  input wire logic aclk,
  // Commands from the bench
  input wire logic [8:0] fail_req,
  input wire logic [1:0] rate_req,
  input wire logic sw_req,
  // Pins to the block
  output dqlc_pkg::dqlc_mon_t mon_fail,
  output dqlc_pkg::dqlc_rate_t ref_rate,
  output logic ref_switch
);
  import dqlc_pkg::*;
  logic sw_q;
  // Pins follow the commands; a switch shows as a one-cycle pulse
  always_ff @(posedge aclk) begin
    mon_fail <= fail_req;
    ref_rate <= dqlc_rate_t'(rate_req);
    sw_q <= sw_req;
    ref_switch <= sw_req & ~sw_q;
  end
endmodule

// ===== test/dqlc_top_test.sv
// Self-checking bench for the reference qualification and loop control block
`timescale 1ns/10ps
`include "dqlc_map.svh"
module dqlc_top_test;
  import dqlc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, sw_req = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic [8:0] fail_req = 9'h000;
  logic [1:0] rate_req = 2'h0;
  logic awready, wready, bvalid, arready, rvalid, ref_switch, phase_buildout, phase_realign, holdover_update;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic [2:0] switch_fail, holdover_fail;
  dqlc_mon_t mon_fail;
  dqlc_rate_t ref_rate;
  dqlc_cfg_t loop_cfg;
  int n_mismatch = 0, checks = 0, cyc = 0, t0;
  // Register rows: index, value after reset, value written, value read back
  logic [5:0] ri[8] = '{`DQLC_IDX_RANGE, `DQLC_IDX_SMASK, `DQLC_IDX_DELAY, `DQLC_IDX_LOOPA, `DQLC_IDX_LOOPB,
    `DQLC_IDX_FMASK, `DQLC_IDX_STAT, 6'h00};
  logic [7:0] rv[8] = '{`DQLC_RST_RANGE, `DQLC_RST_SMASK, `DQLC_RST_DELAY, `DQLC_RST_LOOPA, `DQLC_RST_LOOPB,
    `DQLC_RST_FMASK, 8'h00, 8'h00};
  // Loop control b rows keep its reserved bits at 01; offset enable is set as if free-running
  logic [7:0] tw[8] = '{8'h05, 8'h00, 8'h01, 8'h1a, 8'hb7, 8'hff, 8'h55, 8'h12};
  logic [7:0] te[8] = '{8'h05, 8'h00, 8'h01, 8'h1a, 8'hb7, 8'hff, 8'h00, 8'h00};

  // Clock and hang guard
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      end_sim();
    end
  end

  dqlc_top #(.TICK_CYCLES(4), .ADDR_W(8)) DUT (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .mon_fail, .ref_rate, .ref_switch, .loop_cfg, .phase_buildout, .phase_realign, .holdover_update,
    .switch_fail, .holdover_fail);
  dqlc_ref_model M (.aclk, .fail_req, .rate_req, .sw_req, .mon_fail, .ref_rate, .ref_switch);

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Bus write: address and data offered together, each released when taken
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= {idx, 2'h0};
    wdata <= {24'h00_0000, d};
    wstrb <= 4'h1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  // Bus read
  task automatic rd_reg(input logic [5:0] idx);
    arvalid <= 1'b1;
    araddr <= {idx, 2'h0};
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    cy(4);
    chk("cfg at reset", 32'(loop_cfg), 32'({3'h3, BW_FAST7, SLOPE_NONE, 4'h0}));
    chk("outs at reset", 32'({switch_fail, holdover_fail, phase_buildout, phase_realign}), 32'h0000_0000);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd_reg(ri[i]);
      chk("reset value", rd, {24'h00_0000, rv[i]});
    end
    for (int i = 0; i < 8; i++) begin
      wr(ri[i], tw[i]);
      chk("bresp", 32'(rsp), 32'((i > 5) ? `DQLC_RESP_SLVERR : `DQLC_RESP_OKAY));
      rd_reg(ri[i]);
      chk("readback", rd, {24'h00_0000, te[i]});
      chk("rresp", 32'(rsp), 32'((i > 6) ? `DQLC_RESP_SLVERR : `DQLC_RESP_OKAY));
    end
    chk("cfg fields", 32'(loop_cfg), 32'({3'h5, BW_890, SLOPE_7U5, 1'b1, 1'b1, 2'h2}));
    // Bandwidth clamp on low-rate references, reserved code keeps the last value
    rate_req <= RATE_2K;
    cy(4);
    chk("bw 2k", 32'(loop_cfg.bw), 32'(BW_14));
    rate_req <= RATE_8K;
    cy(4);
    chk("bw 8k", 32'(loop_cfg.bw), 32'(BW_56));
    wr(`DQLC_IDX_LOOPA, 8'h3e);
    cy(2);
    chk("bw reserved", 32'(loop_cfg.bw), 32'(BW_56));
    // Switch handling for build-out and realign
    for (int j = 0; j < 2; j++) begin
      wr(`DQLC_IDX_LOOPA, 8'h3e | 8'(j));
      sw_req <= 1'b1;
      cy(3);
      chk("switch pulse", 32'({phase_buildout, phase_realign}), (j == 1) ? 32'h0000_0001 : 32'h0000_0002);
      sw_req <= 1'b0;
      cy(1);
      chk("switch end", 32'({phase_buildout, phase_realign}), 32'h0000_0000);
    end
    // Single-cycle failure on reference 0, then the soak timer holds it through requalify
    fail_req <= 9'h040;
    cy(5);
    chk("scm fail", 32'({switch_fail, holdover_fail}), 32'h0000_0009);
    cy(20);
    rd_reg(`DQLC_IDX_STAT);
    chk("soak failed", rd, 32'h0000_0001);
    fail_req <= 9'h000;
    cy(6);
    chk("soak holds", 32'(switch_fail), 32'h0000_0001);
    cy(30);
    chk("soak clear", 32'(switch_fail), 32'h0000_0000);
    // Soak masks: inhibited single-cycle input, live coarse frequency input
    wr(`DQLC_IDX_SMASK, 8'h01);
    wr(`DQLC_IDX_FMASK, 8'h04);
    wr(`DQLC_IDX_DELAY, 8'h10);
    fail_req <= 9'h040;
    cy(40);
    chk("scm inhibited", 32'(switch_fail), 32'h0000_0000);
    // Zero drop code: soak fails at the edge after the synchronised failure
    fail_req <= 9'h048;
    cy(5);
    chk("soak not yet", 32'(switch_fail), 32'h0000_0000);
    cy(1);
    chk("soak at once", 32'(switch_fail), 32'h0000_0001);
    cy(34);
    chk("cfm to soak", 32'(switch_fail), 32'h0000_0001);
    // Switching indicators all masked, holdover indicators all live
    wr(`DQLC_IDX_FMASK, 8'hf0);
    cy(3);
    chk("hold only", 32'({switch_fail, holdover_fail}), 32'h0000_0001);
    fail_req <= 9'h000;
    // Holdover refresh interval at the shortest code
    wr(`DQLC_IDX_LOOPB, 8'h05);
    do @(posedge aclk); while (!holdover_update);
    t0 = cyc;
    do @(posedge aclk); while (!holdover_update);
    chk("holdover period", 32'(cyc - t0), 32'(52 * 4));
    // Mid-run reset brings configuration and registers back to defaults
    aresetn <= 1'b0;
    cy(3);
    chk("cfg after reset", 32'(loop_cfg), 32'({3'h3, BW_FAST7, SLOPE_NONE, 4'h0}));
    aresetn <= 1'b1;
    rd_reg(`DQLC_IDX_LOOPB);
    chk("loop b after reset", rd, {24'h00_0000, `DQLC_RST_LOOPB});
    end_sim();
  end
endmodule
